// file: core/pboa_pkg.sv
// Constants, types and lane-swap helpers for the peripheral byte order adapter
package pboa_pkg;

   // ---------------------------------------------------------------
   // Widths and depths
   // ---------------------------------------------------------------
   localparam int DATA_W     = 32;
   localparam int HALF_W     = 16;
   localparam int FIFO_DEPTH = 32;

   // ---------------------------------------------------------------
   // Sample format codes
   // ---------------------------------------------------------------
   localparam logic [1:0] CAP_FMT_MONO8     = 2'h0;
   localparam logic [1:0] CAP_FMT_STEREO8   = 2'h1;
   localparam logic [1:0] CAP_FMT_MONO16    = 2'h2;
   localparam logic [1:0] CAP_FMT_STEREO16  = 2'h3;
   localparam logic [1:0] PLAY_FMT_MONO16   = 2'h0;
   localparam logic [1:0] PLAY_FMT_STEREO16 = 2'h1;
   localparam logic [1:0] PLAY_FMT_MONO32   = 2'h2;
   localparam logic [1:0] PLAY_FMT_STEREO32 = 2'h3;
   // Format bit that marks the wider element size
   localparam int FMT_WIDE_BIT = 1;

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic RST_LITTLE   = 1'b0;   // Big-endian out of reset
   localparam logic RST_SWAP_EN  = 1'b0;
   localparam logic RST_HALF_ORD = 1'b0;
   localparam int   SWAP_EN_BIT  = 0;      // Swap enable bit in bus interface control word

   typedef enum logic [1:0] {SER_IDLE, SER_FIRST, SER_SECOND} pboa_ser_t;

   // Full four-lane reversal of a word
   function automatic logic [31:0] swap_word(input logic [31:0] w);
      swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : swap_word

   // Byte reversal inside each half-word
   function automatic logic [31:0] swap_halves(input logic [31:0] w);
      swap_halves = {w[23:16], w[31:24], w[7:0], w[15:8]};
   endfunction : swap_halves

endpackage : pboa_pkg

// file: core/pboa_top.sv
// Byte-lane ordering between media peripherals and the 32-bit memory highway
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Word FIFO with registered input ready
// -------------------------------------------------------------------
module pboa_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 32
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr_ptr;
      logic [AW-1:0]           rd_ptr;
      logic [AW:0]             count;
      logic                    in_ready;
   } pboa_fifo_st_t;

   pboa_fifo_st_t st_ff;
   pboa_fifo_st_t nxt_st;
   logic          push;
   logic          pop;

   assign out_valid = (st_ff.count != '0);
   assign out_data  = st_ff.mem[st_ff.rd_ptr];
   assign in_ready  = st_ff.in_ready;
   assign push      = in_valid && st_ff.in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr_ptr] = in_data;
         nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
      end
      case ({push, pop})
         2'b10:   nxt_st.count = st_ff.count + 1'b1;
         2'b01:   nxt_st.count = st_ff.count - 1'b1;
         default: nxt_st.count = st_ff.count;
      endcase
      nxt_st.in_ready = (nxt_st.count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff          <= '0;
         st_ff.in_ready <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : pboa_fifo

// -------------------------------------------------------------------
// Adapter top
// -------------------------------------------------------------------
module pboa_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   // Configuration
   input  wire logic        cfg_wr,
   input  wire logic        cfg_capture_little,
   input  wire logic        cfg_playback_little,
   input  wire logic        cfg_dec_little,
   input  wire logic        cfg_half_word_order_select,
   output logic [4:0]       cfg_status,
   // Capture unit
   input  wire logic        cap_valid,
   input  wire logic [1:0]  cap_fmt,
   input  wire logic [31:0] cap_data,
   output logic             cap_mem_valid,
   output logic [31:0]      cap_mem_data,
   // Playback unit
   input  wire logic        play_mem_valid,
   input  wire logic [1:0]  play_fmt,
   input  wire logic [31:0] play_mem_data,
   output logic             play_valid,
   output logic [31:0]      play_data,
   // Digital audio output unit
   input  wire logic        dao_mem_valid,
   input  wire logic [31:0] dao_mem_data,
   output logic             dao_valid,
   output logic [31:0]      dao_data,
   // Variable length decoder
   input  wire logic        dec_in_valid,
   input  wire logic [31:0] dec_in_data,
   output logic             dec_bs_valid,
   output logic [31:0]      dec_bs_data,
   input  wire logic        dec_hdr_valid,
   input  wire logic [31:0] dec_hdr_word,
   output logic             dec_hdr_mem_valid,
   output logic [31:0]      dec_hdr_mem_data,
   input  wire logic        dec_rl_valid,
   input  wire logic [15:0] dec_run,
   input  wire logic [15:0] dec_level,
   output logic             dec_rl_mem_valid,
   output logic [31:0]      dec_rl_mem_data,
   // Sync serial port
   input  wire logic        ssp_wr_valid,
   input  wire logic [31:0] ssp_wr_data,
   output logic             ssp_wr_ready,
   output logic             ssp_tx_valid,
   output logic [15:0]      ssp_tx_half,
   input  wire logic        ssp_tx_ready,
   input  wire logic        ssp_rx_valid,
   input  wire logic [15:0] ssp_rx_half,
   output logic             ssp_rd_valid,
   output logic [31:0]      ssp_rd_word,
   // Host register path
   input  wire logic        host_wr,
   input  wire logic        host_wr_biu,
   input  wire logic [31:0] host_wdata,
   output logic             reg_wr_valid,
   output logic [31:0]      reg_wdata,
   input  wire logic        reg_rd_valid,
   input  wire logic [31:0] reg_rdata,
   output logic             host_rd_valid,
   output logic [31:0]      host_rdata,
   output logic             host_bus_swap_enable
);

   typedef struct packed {
      logic               cap_little;
      logic               play_little;
      logic               dec_little;
      logic               half_order;
      logic               swap_en;
      logic [4:0]         status;
      logic               cap_valid;
      logic [31:0]        cap_data;
      logic               play_valid;
      logic [31:0]        play_data;
      logic               dao_valid;
      logic [31:0]        dao_data;
      logic               bs_valid;
      logic [31:0]        bs_data;
      logic               hdr_valid;
      logic [31:0]        hdr_data;
      logic               rl_valid;
      logic [31:0]        rl_data;
      pboa_pkg::pboa_ser_t ser_state;
      logic [31:0]        ser_word;
      logic               ser_low_first;
      logic               tx_valid;
      logic [15:0]        tx_half;
      logic               rx_have_first;
      logic [15:0]        rx_first;
      logic               rd_valid;
      logic [31:0]        rd_word;
      logic               reg_wr_valid;
      logic [31:0]        reg_wdata;
      logic               rd_back_valid;
      logic [31:0]        rd_back_data;
   } pboa_st_t;

   pboa_st_t    st_ff;
   pboa_st_t    nxt_st;
   logic        fifo_valid;
   logic [31:0] fifo_data;
   logic        fifo_pop;
   logic [31:0] host_in;

   // -------------------------------------------------------------------
   // Serial transmit buffer
   // -------------------------------------------------------------------
   // Words land here as written; a stalled serial link back-pressures the highway
   pboa_fifo #(.W(pboa_pkg::DATA_W), .DEPTH(pboa_pkg::FIFO_DEPTH)) u_tx_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (ssp_wr_valid),
      .in_data   (ssp_wr_data),
      .in_ready  (ssp_wr_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

   assign fifo_pop = (st_ff.ser_state == pboa_pkg::SER_IDLE);

   // The write that sets the swap bit is itself decoded under the old setting
   assign host_in = st_ff.swap_en ? host_wdata : pboa_pkg::swap_word(host_wdata);

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (cfg_wr) begin
         nxt_st.cap_little  = cfg_capture_little;
         nxt_st.play_little = cfg_playback_little;
         nxt_st.dec_little  = cfg_dec_little;
         nxt_st.half_order  = cfg_half_word_order_select;
      end
      // Host side: swapped unless enabled
      nxt_st.reg_wr_valid = host_wr;
      if (host_wr) begin
         nxt_st.reg_wdata = host_in;
         if (host_wr_biu) begin
            nxt_st.swap_en = host_in[pboa_pkg::SWAP_EN_BIT];
         end
      end
      nxt_st.rd_back_valid = reg_rd_valid;
      if (reg_rd_valid) begin
         nxt_st.rd_back_data = st_ff.swap_en ? reg_rdata
                               : pboa_pkg::swap_word(reg_rdata);
      end
      nxt_st.status = {nxt_st.swap_en, nxt_st.half_order, nxt_st.dec_little,
                       nxt_st.play_little, nxt_st.cap_little};

      // Capture: 8-bit elements stay put, 16-bit elements swap in big-endian
      nxt_st.cap_valid = cap_valid;
      if (cap_valid) begin
         if (!st_ff.cap_little && cap_fmt[pboa_pkg::FMT_WIDE_BIT]) begin
            nxt_st.cap_data = pboa_pkg::swap_halves(cap_data);
         end else begin
            nxt_st.cap_data = cap_data;
         end
      end

      // Playback: in big-endian, 16-bit elements swap per half, 32-bit per word
      nxt_st.play_valid = play_mem_valid;
      if (play_mem_valid) begin
         if (st_ff.play_little) begin
            nxt_st.play_data = play_mem_data;
         end else if (play_fmt[pboa_pkg::FMT_WIDE_BIT]) begin
            nxt_st.play_data = pboa_pkg::swap_word(play_mem_data);
         end else begin
            nxt_st.play_data = pboa_pkg::swap_halves(play_mem_data);
         end
      end

      // Digital audio output: word granular, follows the playback order bit
      nxt_st.dao_valid = dao_mem_valid;
      if (dao_mem_valid) begin
         nxt_st.dao_data = st_ff.play_little ? dao_mem_data
                           : pboa_pkg::swap_word(dao_mem_data);
      end

      // Decoder: bitstream is byte oriented, outputs are word oriented
      nxt_st.bs_valid = dec_in_valid;
      if (dec_in_valid) begin
         nxt_st.bs_data = dec_in_data;
      end
      nxt_st.hdr_valid = dec_hdr_valid;
      if (dec_hdr_valid) begin
         nxt_st.hdr_data = st_ff.dec_little ? dec_hdr_word
                           : pboa_pkg::swap_word(dec_hdr_word);
      end
      nxt_st.rl_valid = dec_rl_valid;
      if (dec_rl_valid) begin
         nxt_st.rl_data = st_ff.dec_little ? {dec_run, dec_level}
                          : pboa_pkg::swap_word({dec_run, dec_level});
      end

      // Serial transmit: one word out as two half-words
      case (st_ff.ser_state)
         pboa_pkg::SER_IDLE: begin
            if (fifo_valid) begin
               nxt_st.ser_word      = fifo_data;
               nxt_st.ser_low_first = st_ff.half_order;
               nxt_st.tx_valid      = 1'b1;
               nxt_st.tx_half       = st_ff.half_order ? fifo_data[15:0]
                                      : fifo_data[31:16];
               nxt_st.ser_state     = pboa_pkg::SER_FIRST;
            end
         end
         pboa_pkg::SER_FIRST: begin
            if (ssp_tx_ready) begin
               nxt_st.tx_half   = st_ff.ser_low_first ? st_ff.ser_word[31:16]
                                  : st_ff.ser_word[15:0];
               nxt_st.ser_state = pboa_pkg::SER_SECOND;
            end
         end
         pboa_pkg::SER_SECOND: begin
            if (ssp_tx_ready) begin
               nxt_st.tx_valid  = 1'b0;
               nxt_st.ser_state = pboa_pkg::SER_IDLE;
            end
         end
         default: begin
            nxt_st.tx_valid  = 1'b0;
            nxt_st.ser_state = pboa_pkg::SER_IDLE;
         end
      endcase

      // Serial receive: pair half-words in the same order
      nxt_st.rd_valid = 1'b0;
      if (ssp_rx_valid) begin
         if (!st_ff.rx_have_first) begin
            nxt_st.rx_have_first = 1'b1;
            nxt_st.rx_first      = ssp_rx_half;
         end else begin
            nxt_st.rx_have_first = 1'b0;
            nxt_st.rd_valid      = 1'b1;
            nxt_st.rd_word       = st_ff.half_order ? {ssp_rx_half, st_ff.rx_first}
                                   : {st_ff.rx_first, ssp_rx_half};
         end
      end
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff             <= '0;
         st_ff.cap_little  <= pboa_pkg::RST_LITTLE;
         st_ff.play_little <= pboa_pkg::RST_LITTLE;
         st_ff.dec_little  <= pboa_pkg::RST_LITTLE;
         st_ff.half_order  <= pboa_pkg::RST_HALF_ORD;
         st_ff.swap_en     <= pboa_pkg::RST_SWAP_EN;
         st_ff.ser_state   <= pboa_pkg::SER_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cfg_status           = st_ff.status;
   assign cap_mem_valid        = st_ff.cap_valid;
   assign cap_mem_data         = st_ff.cap_data;
   assign play_valid           = st_ff.play_valid;
   assign play_data            = st_ff.play_data;
   assign dao_valid            = st_ff.dao_valid;
   assign dao_data             = st_ff.dao_data;
   assign dec_bs_valid         = st_ff.bs_valid;
   assign dec_bs_data          = st_ff.bs_data;
   assign dec_hdr_mem_valid    = st_ff.hdr_valid;
   assign dec_hdr_mem_data     = st_ff.hdr_data;
   assign dec_rl_mem_valid     = st_ff.rl_valid;
   assign dec_rl_mem_data      = st_ff.rl_data;
   assign ssp_tx_valid         = st_ff.tx_valid;
   assign ssp_tx_half          = st_ff.tx_half;
   assign ssp_rd_valid         = st_ff.rd_valid;
   assign ssp_rd_word          = st_ff.rd_word;
   assign reg_wr_valid         = st_ff.reg_wr_valid;
   assign reg_wdata            = st_ff.reg_wdata;
   assign host_rd_valid        = st_ff.rd_back_valid;
   assign host_rdata           = st_ff.rd_back_data;
   assign host_bus_swap_enable = st_ff.swap_en;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_word_taken;
      st_ff.ser_state == pboa_pkg::SER_IDLE && fifo_valid;
   endsequence

   sequence s_first_half;
      ssp_tx_valid && ssp_tx_half == ($past(st_ff.half_order) ? $past(fifo_data[15:0])
                                      : $past(fifo_data[31:16]));
   endsequence

   sequence s_second_half;
      ssp_tx_valid && ssp_tx_half == (st_ff.ser_low_first ? st_ff.ser_word[31:16]
                                      : st_ff.ser_word[15:0]);
   endsequence

   a_order_bits_held: assert property ($changed(cfg_status[2:0]) |-> $past(cfg_wr))
      else $error("byte-order bit moved without a config write");
   a_cap_wide_swap: assert property (cap_valid && !st_ff.cap_little && cap_fmt[1]
      |=> cap_mem_valid && cap_mem_data == pboa_pkg::swap_halves($past(cap_data)))
      else $error("16-bit capture sample not swapped");
   a_cap_byte_pass: assert property (cap_valid && !cap_fmt[1]
      |=> cap_mem_data == $past(cap_data))
      else $error("8-bit capture sample disturbed");
   a_play_little_pass: assert property (play_mem_valid && st_ff.play_little
      |=> play_valid && play_data == $past(play_mem_data))
      else $error("little-endian playback data altered");
   a_play_word_swap: assert property (play_mem_valid && !st_ff.play_little && play_fmt[1]
      |=> play_data[7:0] == $past(play_mem_data[31:24]))
      else $error("32-bit playback sample not reversed");
   a_dao_word_swap: assert property (dao_mem_valid && !st_ff.play_little
      |=> dao_valid && dao_data[31:24] == $past(dao_mem_data[7:0]))
      else $error("digital audio word lanes wrong");
   a_dec_bs_pass: assert property (dec_in_valid
      |=> dec_bs_valid && dec_bs_data == $past(dec_in_data))
      else $error("decoder bitstream swapped");
   a_dec_hdr_lanes: assert property (dec_hdr_valid && !st_ff.dec_little
      |=> dec_hdr_mem_data[7:0] == $past(dec_hdr_word[31:24])
          && dec_hdr_mem_data[31:24] == $past(dec_hdr_word[7:0]))
      else $error("decoder header lanes wrong");
   a_dec_rl_lanes: assert property (dec_rl_valid && !st_ff.dec_little
      |=> dec_rl_mem_data[15:0] == {$past(dec_run[7:0]), $past(dec_run[15:8])})
      else $error("run-level lanes wrong");
   a_ssp_half_order: assert property (s_word_taken ##1 s_first_half ##0 ssp_tx_ready
      |=> s_second_half)
      else $error("serial half-word order wrong");
   a_ssp_first_out: assert property (s_word_taken |=> s_first_half)
      else $error("serial first half-word wrong");
   a_host_swap: assert property (host_wr && !st_ff.swap_en
      |=> reg_wr_valid && reg_wdata == pboa_pkg::swap_word($past(host_wdata)))
      else $error("host data not swapped while swap enable low");

endmodule : pboa_top

// file: dv/pboa_link_sink.sv
// Serial link partner: accepts half-words slowly or stalls, logs them
`timescale 1ns/1ps
module pboa_link_sink (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        stall,
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_half,
   output logic             tx_ready
);
   logic [15:0] got [$];
   // Ready every other cycle, so each second half waits at least once
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_ready <= 1'b0;
      end else begin
         if (tx_valid && tx_ready) got.push_back(tx_half);
         tx_ready <= !stall && !tx_ready;
      end
   end
endmodule : pboa_link_sink

// file: dv/testbench.sv
// Self-checking bench for the peripheral byte order adapter
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] D = 32'h11223344;
   logic        clk, resetn, cfg_wr, cfg_capture_little, cfg_playback_little, cfg_dec_little;
   logic        cfg_half_word_order_select, cap_valid, play_mem_valid, dao_mem_valid;
   logic        dec_in_valid, dec_hdr_valid, dec_rl_valid, ssp_wr_valid, ssp_tx_ready;
   logic        ssp_rx_valid, host_wr, host_wr_biu, reg_rd_valid, stall;
   logic        cap_mem_valid, play_valid, dao_valid, dec_bs_valid, dec_hdr_mem_valid;
   logic        dec_rl_mem_valid, ssp_wr_ready, ssp_tx_valid, ssp_rd_valid, reg_wr_valid;
   logic        host_rd_valid, host_bus_swap_enable;
   logic [1:0]  cap_fmt, play_fmt;
   logic [4:0]  cfg_status;
   logic [15:0] dec_run, dec_level, ssp_tx_half, ssp_rx_half;
   logic [31:0] cap_data, play_mem_data, dao_mem_data, dec_in_data, dec_hdr_word;
   logic [31:0] ssp_wr_data, host_wdata, reg_rdata, cap_mem_data, play_data, dao_data;
   logic [31:0] dec_bs_data, dec_hdr_mem_data, dec_rl_mem_data, ssp_rd_word, reg_wdata;
   logic [31:0] host_rdata;
   int          fails, n_checks, n, k;
   wire [7:0][32:0] outs = {{cap_mem_valid, cap_mem_data}, {play_valid, play_data},
      {dao_valid, dao_data}, {dec_bs_valid, dec_bs_data}, {dec_hdr_mem_valid, dec_hdr_mem_data},
      {dec_rl_mem_valid, dec_rl_mem_data}, {reg_wr_valid, reg_wdata}, {host_rd_valid, host_rdata}};

   pboa_top i_dut (.*);
   pboa_link_sink u_sink (.clk(clk), .resetn(resetn), .stall(stall), .tx_valid(ssp_tx_valid),
                          .tx_half(ssp_tx_half), .tx_ready(ssp_tx_ready));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------
   // Helpers
   // ----------
   function automatic logic [31:0] rev(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : rev
   function automatic logic [31:0] hsw(input logic [31:0] w);
      return {w[23:16], w[31:24], w[7:0], w[15:8]};
   endfunction : hsw
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // One word into stream s; its answer must stand exactly one cycle later
   task automatic strm(input int s, input logic [1:0] f, input logic [31:0] d,
                       input logic [31:0] e);
      @(posedge clk); #1;
      {cap_data, play_mem_data, dao_mem_data, dec_in_data, dec_hdr_word} = {5{d}};
      {dec_run, dec_level} = d;
      host_wdata = d;
      reg_rdata = d;
      {cap_fmt, play_fmt} = {f, f};
      host_wr_biu = f[0];
      {cap_valid, play_mem_valid, dao_mem_valid, dec_in_valid, dec_hdr_valid, dec_rl_valid,
       host_wr, reg_rd_valid} = 8'h80 >> s;
      @(posedge clk); #1;
      {cap_valid, play_mem_valid, dao_mem_valid, dec_in_valid, dec_hdr_valid, dec_rl_valid,
       host_wr, reg_rd_valid} = 8'h00;
      chk(outs[7-s], {1'b1, e});
   endtask : strm
   task automatic cfg(input logic [4:0] e);
      @(posedge clk); #1;
      {cfg_half_word_order_select, cfg_dec_little, cfg_playback_little, cfg_capture_little} = e[3:0];
      cfg_wr = 1'b1;
      @(posedge clk); #1;
      cfg_wr = 1'b0;
      chk(cfg_status, e);
   endtask : cfg
   task automatic wait_got(input int m);
      // Step off the edge so the sink's log is settled and later drives are clean
      for (k = 0; k < 2000 && u_sink.got.size() < m; k++) begin
         @(posedge clk); #1;
      end
      chk(u_sink.got.size(), m);
      if (k == 2000) give_verdict();
   endtask : wait_got
   // Two received half-words must pair into one word, no word after the first
   task automatic rxp(input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
      @(posedge clk); #1;
      ssp_rx_valid = 1'b1;
      ssp_rx_half = a;
      @(posedge clk); #1;
      ssp_rx_half = b;
      chk(ssp_rd_valid, 1'b0);
      @(posedge clk); #1;
      ssp_rx_valid = 1'b0;
      chk({ssp_rd_valid, ssp_rd_word}, {1'b1, e});
   endtask : rxp

   // ----------
   // Main sequence
   // ----------
   initial begin
      {resetn, cfg_wr, cfg_capture_little, cfg_playback_little, cfg_dec_little, stall} = '0;
      {cfg_half_word_order_select, cap_valid, play_mem_valid, dao_mem_valid, dec_in_valid} = '0;
      {dec_hdr_valid, dec_rl_valid, ssp_wr_valid, ssp_rx_valid, host_wr, host_wr_biu} = '0;
      {reg_rd_valid, cap_fmt, play_fmt, dec_run, dec_level, ssp_rx_half} = '0;
      {cap_data, play_mem_data, dao_mem_data, dec_in_data, dec_hdr_word} = '0;
      {ssp_wr_data, host_wdata, reg_rdata, fails, n_checks, n} = '0;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      chk({cfg_status, host_bus_swap_enable, ssp_wr_ready}, 7'h01);
      for (int i = 0; i < 4; i++) begin
         strm(0, i[1:0], D, i[1] ? hsw(D) : D);
         strm(1, i[1:0], D, i[1] ? rev(D) : hsw(D));
      end
      strm(2, 0, D, rev(D));
      strm(3, 0, D, D);
      strm(4, 0, 32'h12345678, 32'h78563412);
      strm(5, 0, 32'h12345678, 32'h78563412);
      cfg(5'h07);
      for (int i = 0; i < 4; i++) begin
         strm(0, i[1:0], D, D);
         strm(1, i[1:0], D, D);
      end
      strm(2, 0, D, D);
      strm(3, 0, D, D);
      strm(4, 0, 32'h12345678, 32'h12345678);
      strm(5, 0, 32'h12345678, 32'h12345678);
      strm(6, 0, 32'haabbccdd, 32'hddccbbaa);
      strm(7, 0, D, rev(D));
      strm(6, 1, 32'h01000000, 32'h00000001);
      chk(host_bus_swap_enable, 1);
      strm(6, 0, D, D);
      strm(7, 0, D, D);
      // Link stalled: 32 words fill the FIFO, one more waits in the shifter
      stall = 1'b1;
      @(posedge clk); #1;
      while (ssp_wr_ready === 1'b1 && n < 40) begin
         ssp_wr_valid = 1'b1;
         ssp_wr_data = {n[15:0], ~n[15:0]};
         @(posedge clk); #1;
         n++;
      end
      ssp_wr_valid = 1'b0;
      chk(n, 33);
      if (n == 40) give_verdict();
      stall = 1'b0;
      wait_got(2 * n);
      for (int i = 0; i < n; i++) begin
         chk(u_sink.got[2*i], i[15:0]);
         chk(u_sink.got[2*i+1], {~i[15:0]});
      end
      rxp(16'h1111, 16'h2222, 32'h11112222);
      cfg(5'h1f);
      ssp_wr_valid = 1'b1;
      ssp_wr_data = 32'h5a5ac3c3;
      @(posedge clk); #1;
      ssp_wr_valid = 1'b0;
      wait_got(2 * n + 2);
      chk(u_sink.got[2*n], 16'hc3c3);
      chk(u_sink.got[2*n+1], 16'h5a5a);
      rxp(16'h1111, 16'h2222, 32'h22221111);
      give_verdict();
   end
endmodule : testbench
